/* hdp_top.sv */
// Overview of operation
// - Data register moves all sixteen bus bits
// - Other registers use low eight bits only
// - Drive requests DMA, handshakes with acknowledge
// - Write strobe rising edge captures host data
// - Drive drives read data while strobe low
// - Data-out words latched on both strobe edges
// - Ready line extends register cycles until ready
// - Drive signals readiness during data-out bursts
// - Drive toggles its strobe during data-in bursts
// - Cable select grounded means master, else slave
// - Interrupt driven only when selected and enabled
// - Pending bit set by controller raises interrupt
// - Wide-access line pulled for ready data register
// - Activity line lights LED except during data-in bursts, reports slave presence
// - Diagnostic line reports presence and results
`timescale 1ns/100ps
`default_nettype none
`include "hdp_regs.svh"
module hdp_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hstrobe_clk,
  input wire logic i_reset_n,
  input wire logic i_cs0_n,
  input wire logic i_cs1_n,
  input wire logic [2:0] i_da,
  input wire logic i_dior_n,
  input wire logic i_diow_n,
  input wire logic i_dmack_n,
  input wire logic i_csel,
  input wire logic i_dasp_n,
  input wire logic i_pdiag_n,
  input wire logic [15:0] i_dd,
  input wire logic i_csel_enable,
  input wire logic i_jumper_master,
  input wire logic i_ready,
  input wire logic i_dma_req,
  input wire logic i_udma,
  input wire logic i_dma_dir_in,
  input wire logic i_irq_set,
  input wire logic i_drq,
  input wire logic i_diag_pass,
  input wire logic [15:0] i_rd_data,
  output logic [15:0] o_dd,
  output logic o_dd_oe_n,
  output logic o_dmarq,
  output logic o_iordy,
  output logic o_iordy_oe_n,
  output logic o_intrq,
  output logic o_intrq_oe_n,
  output logic o_iocs16,
  output logic o_iocs16_oe_n,
  output logic o_dasp,
  output logic o_dasp_oe_n,
  output logic o_pdiag,
  output logic o_pdiag_oe_n,
  output logic o_host_reset,
  output logic o_host_wr,
  output logic o_host_rd,
  output hdp_pkg::hdp_addr_type o_addr,
  output logic [15:0] o_wr_data,
  output logic o_irq_pending,
  output logic o_is_master,
  output logic o_slave_present,
  output logic o_slave_diag_ok
);
  import hdp_pkg::*;

  hdp_core_type st;
  hdp_core_type next_st;
  hdp_pins_type pin;
  logic [1:0] tog;
  logic [15:0] word_rise;
  logic [15:0] word_fall;
  logic tog_rise;
  logic tog_fall;
  logic cmd_grp;
  logic ctl_grp;
  logic sel;
  logic dma_ack;
  logic is_data;
  logic diow_rise;
  logic dior_rise;
  logic pio_wr;
  logic rd_act;
  logic clr_irq;
  logic burst_end;

  hdp_sync #(.W(28), .INIT(`HDP_PINS_IDLE)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_reset_n, i_cs0_n, i_cs1_n, i_da, i_dior_n, i_diow_n, i_dmack_n,
          i_csel, i_dasp_n, i_pdiag_n, i_dd}),
    .o_q(pin)
  );

  // Link side: one word per strobe edge, announced by a toggle
  always_ff @(posedge i_hstrobe_clk or posedge i_rst) begin
    if (i_rst) begin
      word_rise <= 16'h0000;
      tog_rise <= 1'b0;
    end else begin
      word_rise <= i_dd;
      tog_rise <= ~tog_rise;
    end
  end

  always_ff @(negedge i_hstrobe_clk or posedge i_rst) begin
    if (i_rst) begin
      word_fall <= 16'h0000;
      tog_fall <= 1'b0;
    end else begin
      word_fall <= i_dd;
      tog_fall <= ~tog_fall;
    end
  end

  // Words stay put for a full strobe period, far longer than the crossing
  hdp_sync #(.W(2), .INIT(2'h0)) u_tog_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({tog_rise, tog_fall}),
    .o_q(tog)
  );

  assign cmd_grp = ~pin.cs0_n & pin.cs1_n;
  assign ctl_grp = pin.cs0_n & ~pin.cs1_n;
  assign sel = st.dev ^ st.master;
  assign dma_ack = ~pin.dmack_n;
  assign is_data = cmd_grp && (pin.da == `HDP_DA_DATA);
  assign diow_rise = ~st.prev_diow_n & pin.diow_n;
  assign dior_rise = ~st.prev_dior_n & pin.dior_n;
  assign pio_wr = diow_rise && !dma_ack && (st.state == HDP_ST_IDLE) && (cmd_grp || ctl_grp);
  assign rd_act = ~pin.dior_n && (st.state == HDP_ST_IDLE)
    && ((sel && (cmd_grp || ctl_grp) && !dma_ack) || (dma_ack && st.dmarq && !i_udma));
  // Stop is the write pin high while acknowledged
  assign burst_end = !dma_ack || pin.diow_n || !pin.reset_n;

  always_comb begin
    next_st = st;
    clr_irq = 1'b0;
    next_st.host_wr = 1'b0;
    next_st.host_rd = 1'b0;
    next_st.od_low = 1'b0;
    next_st.prev_dior_n = pin.dior_n;
    next_st.prev_diow_n = pin.diow_n;
    next_st.prev_tog = tog;
    next_st.prev_drq = i_drq;
    next_st.host_reset = ~pin.reset_n;
    if (st.led_cnt != 8'h00) begin
      next_st.led_cnt = st.led_cnt - 8'h01;
    end
    // Strap is followed while the host holds reset
    if (~pin.reset_n || ~st.strap_done) begin
      next_st.master = i_csel_enable ? ~pin.csel : i_jumper_master;
      next_st.strap_done = pin.reset_n;
    end
    if (cmd_grp || ctl_grp) begin
      next_st.addr = '{cs0_n: pin.cs0_n, cs1_n: pin.cs1_n, da: pin.da};
    end else if (dma_ack) begin
      next_st.addr = '{cs0_n: 1'b0, cs1_n: 1'b1, da: `HDP_DA_DATA};
    end
    // Register writes
    if (pio_wr) begin
      if (cmd_grp && (pin.da == `HDP_DA_DEVHEAD)) begin
        next_st.dev = pin.dd[`HDP_DEV_BIT];
      end
      if (sel) begin
        next_st.host_wr = 1'b1;
        next_st.wr_data = is_data ? pin.dd : {8'h00, pin.dd[7:0]};
        next_st.led_cnt = 8'(`HDP_LED_HOLD_CYC);
        if (ctl_grp && (pin.da == `HDP_DA_DEVCTL)) begin
          next_st.nien = pin.dd[`HDP_NIEN_BIT];
        end
        if (cmd_grp && (pin.da == `HDP_DA_CMDSTAT)) begin
          clr_irq = 1'b1;
          next_st.presence = 1'b0;
        end
      end
    end
    // Multiword DMA write
    if (diow_rise && dma_ack && st.dmarq && !i_udma && (st.state == HDP_ST_IDLE)) begin
      next_st.host_wr = 1'b1;
      next_st.wr_data = pin.dd;
      next_st.led_cnt = 8'(`HDP_LED_HOLD_CYC);
    end
    // Read completes at the strobe rise, where the host latches
    if (dior_rise && !st.dd_oe_n && (st.state == HDP_ST_IDLE)) begin
      next_st.host_rd = 1'b1;
      next_st.led_cnt = 8'(`HDP_LED_HOLD_CYC);
      if (cmd_grp && (pin.da == `HDP_DA_CMDSTAT)) begin
        clr_irq = 1'b1;
      end
    end
    if (st.prev_drq && !i_drq) begin
      clr_irq = 1'b1;
    end
    // A new event beats a clear in the same cycle
    if (clr_irq || ~pin.reset_n) begin
      next_st.irq = 1'b0;
    end
    if (i_irq_set) begin
      next_st.irq = 1'b1;
    end
    if (~pin.reset_n) begin
      next_st.dev = 1'b0;
      next_st.nien = 1'b0;
      next_st.presence = 1'b1;
      next_st.slave_present = 1'b0;
    end
    next_st.dmarq = i_dma_req && sel && pin.reset_n;
    case (st.state)
      HDP_ST_IDLE: begin
        next_st.udma_cnt = 4'h0;
        next_st.dstb = 1'b1;
        if (dma_ack && st.dmarq && i_udma && !burst_end) begin
          next_st.state = i_dma_dir_in ? HDP_ST_UDMA_IN : HDP_ST_UDMA_OUT;
        end
      end
      HDP_ST_UDMA_IN: begin
        if (burst_end) begin
          next_st.state = HDP_ST_IDLE;
        end else if (~pin.dior_n) begin
          if (st.udma_cnt == 4'(`HDP_UDMA_HALF_CYC - 1)) begin
            next_st.dstb = ~st.dstb;
            next_st.host_rd = 1'b1;
            next_st.udma_cnt = 4'h0;
          end else begin
            next_st.udma_cnt = st.udma_cnt + 4'h1;
          end
        end
      end
      HDP_ST_UDMA_OUT: begin
        if (burst_end) begin
          next_st.state = HDP_ST_IDLE;
        end else if (tog != st.prev_tog) begin
          next_st.host_wr = 1'b1;
          next_st.wr_data = (tog[1] != st.prev_tog[1]) ? word_rise : word_fall;
          next_st.led_cnt = 8'(`HDP_LED_HOLD_CYC);
        end
      end
      default: begin
        next_st.state = HDP_ST_IDLE;
      end
    endcase
    // Pin drive follows the state being entered
    next_st.dd_oe_n = 1'b1;
    next_st.iordy_oe_n = 1'b1;
    next_st.iordy = i_ready;
    case (next_st.state)
      HDP_ST_IDLE: begin
        if (rd_act) begin
          next_st.dd_oe_n = 1'b0;
          next_st.dd_out = (is_data || dma_ack) ? i_rd_data : {8'h00, i_rd_data[7:0]};
        end
        next_st.iordy_oe_n = ~(sel && (cmd_grp || ctl_grp) && !dma_ack);
      end
      HDP_ST_UDMA_IN: begin
        next_st.dd_oe_n = 1'b0;
        next_st.dd_out = i_rd_data;
        next_st.iordy_oe_n = 1'b0;
        next_st.iordy = next_st.dstb;
      end
      HDP_ST_UDMA_OUT: begin
        next_st.iordy_oe_n = 1'b0;
        next_st.iordy = ~i_ready;
      end
      default: begin
        next_st.dd_oe_n = 1'b1;
      end
    endcase
    next_st.iocs16_oe_n = ~((next_st.state == HDP_ST_IDLE) && sel && is_data && i_ready);
    next_st.intrq = next_st.irq;
    next_st.intrq_oe_n = ~((next_st.dev ^ next_st.master) && ~next_st.nien);
    // LED lets go early so the synchronised line is quiet before the master looks
    next_st.dasp_oe_n = ~((next_st.led_cnt > 8'(`HDP_LED_SETTLE_CYC)) || (~next_st.master && next_st.presence));
    next_st.pdiag_oe_n = ~(~next_st.master && i_diag_pass && pin.reset_n);
    if (st.master && (st.led_cnt == 8'h00) && (~pin.dasp_n || ~pin.pdiag_n)) begin
      next_st.slave_present = 1'b1;
    end
    next_st.slave_diag_ok = st.master && ~pin.pdiag_n;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.prev_dior_n <= 1'b1;
      st.prev_diow_n <= 1'b1;
      st.dd_oe_n <= 1'b1;
      st.iordy_oe_n <= 1'b1;
      st.intrq_oe_n <= 1'b1;
      st.iocs16_oe_n <= 1'b1;
      st.dasp_oe_n <= 1'b1;
      st.pdiag_oe_n <= 1'b1;
      st.dstb <= 1'b1;
      st.addr <= 5'h18;
    end else begin
      st <= next_st;
    end
  end

  assign o_dd = st.dd_out;
  assign o_dd_oe_n = st.dd_oe_n;
  assign o_dmarq = st.dmarq;
  assign o_iordy = st.iordy;
  assign o_iordy_oe_n = st.iordy_oe_n;
  assign o_intrq = st.intrq;
  assign o_intrq_oe_n = st.intrq_oe_n;
  assign o_iocs16 = st.od_low;
  assign o_iocs16_oe_n = st.iocs16_oe_n;
  assign o_dasp = st.od_low;
  assign o_dasp_oe_n = st.dasp_oe_n;
  assign o_pdiag = st.od_low;
  assign o_pdiag_oe_n = st.pdiag_oe_n;
  assign o_host_reset = st.host_reset;
  assign o_host_wr = st.host_wr;
  assign o_host_rd = st.host_rd;
  assign o_addr = st.addr;
  assign o_wr_data = st.wr_data;
  assign o_irq_pending = st.irq;
  assign o_is_master = st.master;
  assign o_slave_present = st.slave_present;
  assign o_slave_diag_ok = st.slave_diag_ok;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_wr_capture: assert property (pio_wr && sel && is_data |=> st.host_wr && st.wr_data == $past(pin.dd)) else $error("write data not captured");
  a_byte_lanes: assert property (pio_wr && sel && !is_data |=> st.wr_data[15:8] == 8'h00) else $error("byte register used high lanes");
  a_read_drive: assert property (rd_act |=> !st.dd_oe_n && st.dd_out[7:0] == $past(i_rd_data[7:0])) else $error("read data not driven");
  a_dmarq_follow: assert property (i_dma_req && sel && pin.reset_n |=> st.dmarq) else $error("dma request not raised");
  a_irq_set: assert property (i_irq_set |=> st.irq && (st.intrq || st.intrq_oe_n)) else $error("pending bit lost");
  a_intrq_gate: assert property (!st.intrq_oe_n |-> !st.nien && sel) else $error("interrupt driven while disabled");
  a_iocs16_data: assert property (!st.iocs16_oe_n |-> st.state == HDP_ST_IDLE && $past(is_data)) else $error("wide line pulled off data register");
  a_iordy_ready: assert property (st.state == HDP_ST_IDLE && !st.iordy_oe_n |-> st.iordy == $past(i_ready)) else $error("ready line wrong");
  a_ddmardy_out: assert property (st.state == HDP_ST_UDMA_OUT |-> !st.iordy_oe_n && st.iordy == !$past(i_ready)) else $error("burst ready wrong");
  a_dstrobe_rate: assert property ($changed(st.dstb) && st.state == HDP_ST_UDMA_IN |=> ($stable(st.dstb) || st.state != HDP_ST_UDMA_IN) [*6]) else $error("strobe toggled too fast");
  a_udma_word: assert property (st.state == HDP_ST_UDMA_OUT && !burst_end && tog != st.prev_tog |=> st.host_wr) else $error("burst word dropped");
  a_status_clear: assert property (dior_rise && !st.dd_oe_n && st.state == HDP_ST_IDLE && cmd_grp && pin.da == `HDP_DA_CMDSTAT && !i_irq_set |=> !st.irq) else $error("status read kept interrupt");

  c_udma_in: cover property (st.state == HDP_ST_UDMA_IN && $changed(st.dstb));
  c_udma_out: cover property (st.state == HDP_ST_UDMA_OUT && st.host_wr);
  c_pio_read: cover property (st.host_rd && st.state == HDP_ST_IDLE);
  c_irq_out: cover property (st.intrq && !st.intrq_oe_n);
endmodule
`default_nettype wire

/* hdp_regs.svh */
`ifndef HDP_REGS_SVH
`define HDP_REGS_SVH

// Core clock rate in MHz
`define HDP_CLK_MHZ 125

// Register addresses on the three address lines
`define HDP_DA_DATA 3'h0
`define HDP_DA_DEVHEAD 3'h6
`define HDP_DA_CMDSTAT 3'h7
`define HDP_DA_DEVCTL 3'h6

// Field positions
`define HDP_DEV_BIT 4
`define HDP_NIEN_BIT 1

// Idle level of the synchronised host pins
`define HDP_PINS_IDLE 28'hE3F_0000

// Timing
`define HDP_UDMA_HALF_NS 56
`define HDP_UDMA_HALF_CYC ((`HDP_UDMA_HALF_NS * `HDP_CLK_MHZ + 999) / 1000)
`define HDP_LED_HOLD_NS 2000
`define HDP_LED_HOLD_CYC ((`HDP_LED_HOLD_NS * `HDP_CLK_MHZ) / 1000)
`define HDP_LED_SETTLE_CYC 8

`endif

/* hdp_pkg.sv */
package hdp_pkg;

  typedef enum logic [1:0] {
    HDP_ST_IDLE = 2'b00,
    HDP_ST_UDMA_IN = 2'b01,
    HDP_ST_UDMA_OUT = 2'b10
  } hdp_state_type;

  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
  } hdp_addr_type;

  typedef struct packed {
    logic reset_n;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic dmack_n;
    logic csel;
    logic dasp_n;
    logic pdiag_n;
    logic [15:0] dd;
  } hdp_pins_type;

  typedef struct packed {
    hdp_state_type state;
    logic master;
    logic strap_done;
    logic dev;
    logic nien;
    logic irq;
    logic prev_drq;
    logic prev_dior_n;
    logic prev_diow_n;
    logic [1:0] prev_tog;
    logic [15:0] dd_out;
    logic dd_oe_n;
    logic dmarq;
    logic iordy;
    logic iordy_oe_n;
    logic intrq;
    logic intrq_oe_n;
    logic od_low;
    logic iocs16_oe_n;
    logic dasp_oe_n;
    logic pdiag_oe_n;
    logic presence;
    logic slave_present;
    logic slave_diag_ok;
    logic host_reset;
    logic host_wr;
    logic host_rd;
    hdp_addr_type addr;
    logic [15:0] wr_data;
    logic dstb;
    logic [3:0] udma_cnt;
    logic [7:0] led_cnt;
  } hdp_core_type;

endpackage

/* hdp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module hdp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } hdp_sync_type;

  hdp_sync_type st;
  hdp_sync_type next_st;

  // Per bit: a change counts once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int b = 0; b < W; b++) begin
      if (st.s2[b] == st.s3[b]) begin
        next_st.q[b] = st.s3[b];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= {INIT, INIT, INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.q;
endmodule
`default_nettype wire

/* hdp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hdp_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_drv_dd,
  input wire logic i_drv_oe_n,
  output logic o_reset_n,
  output logic o_cs0_n,
  output logic o_cs1_n,
  output logic [2:0] o_da,
  output logic o_dior_n,
  output logic o_diow_n,
  output logic o_dmack_n,
  output logic o_hstrobe,
  output logic [15:0] o_bus
);
  import hdp_pkg::*;
  logic [15:0] hdd = 16'h0000;
  logic hoe = 1'h0;
  logic [15:0] last = 16'h0000;
  // No pull on data lines, so a released bus flips every cycle
  assign o_bus = !i_drv_oe_n ? i_drv_dd : hoe ? hdd : ~last;
  always @(posedge i_clk) last <= o_bus;
  initial begin
    o_reset_n = 1'h0;
    o_cs0_n = 1'h1;
    o_cs1_n = 1'h1;
    o_da = 3'h0;
    o_dior_n = 1'h1;
    o_diow_n = 1'h1;
    o_dmack_n = 1'h1;
    o_hstrobe = 1'h0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic power_up();
    cyc(10);
    o_reset_n = 1'h1;
    cyc(10);
  endtask
  task automatic set_addr(input hdp_addr_type a);
    @(negedge i_clk);
    {o_cs0_n, o_cs1_n, o_da} = a;
  endtask
  task automatic wr(input hdp_addr_type a, input logic [15:0] d, input logic dma);
    set_addr(a);
    o_dmack_n = !dma;
    hdd = d;
    hoe = 1'h1;
    cyc(2);
    o_diow_n = 1'h0;
    cyc(6);
    o_diow_n = 1'h1;
    cyc(2);
    hoe = 1'h0;
    o_dmack_n = 1'h1;
    cyc(6);
  endtask
  task automatic rd(input hdp_addr_type a, input logic dma, output logic [15:0] q);
    set_addr(a);
    o_dmack_n = !dma;
    cyc(2);
    o_dior_n = 1'h0;
    cyc(8);
    q = o_bus;
    o_dior_n = 1'h1;
    cyc(2);
    o_dmack_n = 1'h1;
    cyc(6);
  endtask
  task automatic udma_in(input int n);
    o_dmack_n = 1'h0;
    o_diow_n = 1'h0;
    o_dior_n = 1'h0;
    cyc(n);
    o_dior_n = 1'h1;
    cyc(20);
    o_diow_n = 1'h1;
    cyc(4);
    o_dmack_n = 1'h1;
    cyc(4);
  endtask
  task automatic udma_out(input logic [15:0] w [$]);
    o_dmack_n = 1'h0;
    o_diow_n = 1'h0;
    hoe = 1'h1;
    cyc(10);
    #3;
    foreach (w[i]) begin
      hdd = w[i];
      #40 o_hstrobe = ~o_hstrobe;
      #40;
    end
    cyc(10);
    o_diow_n = 1'h1;
    cyc(4);
    o_dmack_n = 1'h1;
    hoe = 1'h0;
    cyc(4);
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "hdp_regs.svh"
module testbench;
  import hdp_pkg::*;
  localparam hdp_addr_type A_DATA = {1'h0, 1'h1, `HDP_DA_DATA};
  localparam hdp_addr_type A_CMD = {1'h0, 1'h1, `HDP_DA_CMDSTAT};
  localparam hdp_addr_type A_HEAD = {1'h0, 1'h1, `HDP_DA_DEVHEAD};
  localparam hdp_addr_type A_CTL = {1'h1, 1'h0, `HDP_DA_DEVCTL};
  localparam hdp_addr_type A_IDLE = {1'h1, 1'h1, 3'h0};
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_ready = 1'h1;
  logic i_dma_req = 1'h0;
  logic i_udma = 1'h0;
  logic i_irq_set = 1'h0;
  logic i_drq = 1'h0;
  logic i_dma_dir_in = 1'h0;
  logic in_burst = 1'h0;
  logic last_strb = 1'h1;
  logic [15:0] i_rd_data = 16'h0000;
  logic i_reset_n, i_cs0_n, i_cs1_n, i_dior_n, i_diow_n, i_dmack_n, i_hstrobe_clk;
  logic [2:0] i_da;
  logic [15:0] i_dd, o_dd, o_wr_data, q, d;
  logic o_dd_oe_n, o_dmarq, o_iordy, o_iordy_oe_n, o_intrq, o_intrq_oe_n, o_iocs16;
  logic o_iocs16_oe_n, o_dasp, o_dasp_oe_n, o_pdiag, o_pdiag_oe_n, o_host_wr, o_host_rd;
  logic o_irq_pending, o_is_master, o_host_reset, o_slave_present, o_slave_diag_ok;
  hdp_addr_type o_addr;
  hdp_addr_type got_a [$];
  hdp_addr_type rd_a [2] = '{A_DATA, A_CMD};
  logic [15:0] got [$], exp_q [$], w [$], lat [$], sent [$];
  int n_lat = 0;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Pulled lines resolve to their pull level when released
  wire dasp_w = o_dasp_oe_n ? 1'h1 : o_dasp;
  wire pdiag_w = o_pdiag_oe_n ? 1'h1 : o_pdiag;
  wire iocs16_w = o_iocs16_oe_n ? 1'h1 : o_iocs16;
  wire iordy_w = o_iordy_oe_n ? 1'h1 : o_iordy;
  wire intrq_w = o_intrq_oe_n ? 1'h0 : o_intrq;

  hdp_top hdp_top_inst (.i_clk, .i_rst, .i_hstrobe_clk, .i_reset_n, .i_cs0_n, .i_cs1_n,
    .i_da, .i_dior_n, .i_diow_n, .i_dmack_n, .i_csel(1'h0), .i_dasp_n(dasp_w),
    .i_pdiag_n(pdiag_w), .i_dd, .i_csel_enable(1'h1), .i_jumper_master(1'h0), .i_ready,
    .i_dma_req, .i_udma, .i_dma_dir_in, .i_irq_set, .i_drq, .i_diag_pass(1'h0),
    .i_rd_data, .o_dd, .o_dd_oe_n, .o_dmarq, .o_iordy, .o_iordy_oe_n, .o_intrq,
    .o_intrq_oe_n, .o_iocs16, .o_iocs16_oe_n, .o_dasp, .o_dasp_oe_n, .o_pdiag,
    .o_pdiag_oe_n, .o_host_reset, .o_host_wr, .o_host_rd, .o_addr, .o_wr_data,
    .o_irq_pending, .o_is_master, .o_slave_present, .o_slave_diag_ok);

  hdp_host_model hdp_host_inst (.i_clk, .i_drv_dd(o_dd), .i_drv_oe_n(o_dd_oe_n),
    .o_reset_n(i_reset_n), .o_cs0_n(i_cs0_n), .o_cs1_n(i_cs1_n), .o_da(i_da),
    .o_dior_n(i_dior_n), .o_diow_n(i_diow_n), .o_dmack_n(i_dmack_n),
    .o_hstrobe(i_hstrobe_clk), .o_bus(i_dd));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  always @(negedge i_clk) begin
    if (o_host_wr === 1'h1) begin
      got.push_back(o_wr_data);
      got_a.push_back(o_addr);
    end
    // Host latches on both strobe edges while the drive holds the line
    if (in_burst && o_iordy_oe_n === 1'h0 && iordy_w !== last_strb) lat.push_back(o_dd);
    last_strb = iordy_w;
    if (in_burst && o_host_rd === 1'h1) begin
      i_rd_data = 16'($urandom);
      sent.push_back(i_rd_data);
    end
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic drain(input hdp_addr_type ea, input logic ca);
    chk(16'(got.size()), 16'(exp_q.size()));
    while (got.size() > 0 && exp_q.size() > 0) begin
      chk(got.pop_front(), exp_q.pop_front());
      if (ca) chk({11'h000, got_a.pop_front()}, {11'h000, ea});
    end
    got.delete();
    got_a.delete();
    exp_q.delete();
  endtask
  task automatic pulse_irq();
    i_irq_set = 1'h1;
    cyc(1);
    i_irq_set = 1'h0;
    cyc(3);
  endtask

  initial begin
    void'($urandom(32'h0000_c885));
    cyc(5);
    chk(o_dd_oe_n, 1'h1);
    chk(o_dmarq, 1'h0);
    i_rst = 1'h0;
    hdp_host_inst.power_up();
    chk(o_is_master, 1'h1);
    chk(o_host_reset, 1'h0);
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      exp_q.push_back(d);
      hdp_host_inst.wr(A_DATA, d, 1'h0);
    end
    drain(A_DATA, 1'h1);
    chk(dasp_w, 1'h0);
    d = 16'($urandom);
    exp_q.push_back({8'h00, d[7:0]});
    hdp_host_inst.wr(A_CMD, d, 1'h0);
    drain(A_CMD, 1'h1);
    foreach (rd_a[i]) begin
      i_rd_data = 16'($urandom);
      hdp_host_inst.rd(rd_a[i], 1'h0, q);
      chk(q, i == 0 ? i_rd_data : {8'h00, i_rd_data[7:0]});
    end
    hdp_host_inst.wr(A_CTL, 16'h0000, 1'h0);
    chk(o_intrq_oe_n, 1'h0);
    i_drq = 1'h1;
    for (int k = 0; k < 3; k++) begin
      pulse_irq();
      chk(intrq_w, 1'h1);
      if (k == 0) hdp_host_inst.rd(A_CMD, 1'h0, q);
      else if (k == 1) hdp_host_inst.wr(A_CMD, 16'h0000, 1'h0);
      else begin
        i_drq = 1'h0;
        cyc(4);
      end
      chk(o_irq_pending, 1'h0);
    end
    // Other drive selected: no interrupt drive and no write accepted
    hdp_host_inst.wr(A_HEAD, 16'h0010, 1'h0);
    chk(o_intrq_oe_n, 1'h1);
    got.delete();
    got_a.delete();
    hdp_host_inst.wr(A_DATA, 16'h5a5a, 1'h0);
    drain(A_DATA, 1'h1);
    hdp_host_inst.wr(A_HEAD, 16'h0000, 1'h0);
    hdp_host_inst.wr(A_CTL, 16'h0002, 1'h0);
    chk(o_intrq_oe_n, 1'h1);
    hdp_host_inst.set_addr(A_DATA);
    cyc(8);
    chk(iocs16_w, 1'h0);
    i_ready = 1'h0;
    cyc(8);
    chk(iocs16_w, 1'h1);
    i_ready = 1'h1;
    i_dma_req = 1'h1;
    cyc(4);
    chk(o_dmarq, 1'h1);
    got.delete();
    got_a.delete();
    for (int i = 0; i < 2; i++) begin
      d = 16'($urandom);
      exp_q.push_back(d);
      hdp_host_inst.wr(A_IDLE, d, 1'h1);
    end
    drain(A_DATA, 1'h1);
    i_rd_data = 16'($urandom);
    hdp_host_inst.rd(A_IDLE, 1'h1, q);
    chk(q, i_rd_data);
    i_udma = 1'h1;
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      w.push_back(d);
      exp_q.push_back(d);
    end
    got.delete();
    got_a.delete();
    fork
      hdp_host_inst.udma_out(w);
      begin
        cyc(20);
        chk(iordy_w, 1'h0);
      end
    join
    drain(A_DATA, 1'h0);
    i_dma_dir_in = 1'h1;
    i_rd_data = 16'($urandom);
    sent.push_back(i_rd_data);
    in_burst = 1'h1;
    fork
      hdp_host_inst.udma_in(60);
      begin
        cyc(70);
        n_lat = lat.size();
        cyc(8);
        chk(16'(lat.size()), 16'(n_lat));
      end
    join
    in_burst = 1'h0;
    chk(16'(sent.size() >= 6), 16'h0001);
    chk(16'(lat.size() + 1), 16'(sent.size()));
    while (lat.size() > 0) chk(lat.pop_front(), sent.pop_front());
    i_dma_req = 1'h0;
    i_udma = 1'h0;
    cyc(4);
    chk(o_dmarq, 1'h0);
    chk(o_slave_present, 1'h0);
    chk(o_slave_diag_ok, 1'h0);
    results();
  end
endmodule
`default_nettype wire
